/* File: design/ssd_params.svh */
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH
// ==========================================================
// Timing
`define SSD_CLK_HZ 10000000
`define SSD_AUTOCLR_S 10
`define SSD_FREE_S 5
`define SSD_DWELL_MS 1000
`define SSD_AUTOCLR_CYC (`SSD_AUTOCLR_S * `SSD_CLK_HZ)
`define SSD_FREE_CYC (`SSD_FREE_S * `SSD_CLK_HZ)
`define SSD_DWELL_CYC (`SSD_DWELL_MS * (`SSD_CLK_HZ / 1000))
`define SSD_CNT_W 27
// ==========================================================
// Display geometry and fixed characters
`define SSD_COLS 24
`define SSD_CH_H 8'h48
`define SSD_CH_V 8'h56
`define SSD_CH_F 8'h46
`define SSD_CH_E 8'h45
`define SSD_CH_U 8'h55
`define SSD_CH_I 8'h49
`define SSD_CH_P 8'h50
`define SSD_CH_SP 8'h20
// ==========================================================
// Register byte offsets
`define SSD_OFF_CTRL 8'h00
`define SSD_OFF_DIAG 8'h04
`define SSD_OFF_TILT 8'h08
`define SSD_OFF_PAIR 8'h0c
`define SSD_OFF_IDENT 8'h10
`define SSD_OFF_STAT 8'h14
// ==========================================================
// Field positions
`define SSD_CTRL_OFF 0
`define SSD_CTRL_ROT 1
`define SSD_CTRL_CFG 2
`define SSD_CTRL_BOOTEND 3
`define SSD_CTRL_WAIT 4
`define SSD_CTRL_XFER 5
`define SSD_DIAG_BLOCK 16
`define SSD_DIAG_SRCK 17
// ==========================================================
// Reset values
`define SSD_CTRL_RST 6'h00
`define SSD_TILT_RST 16'h0000
`define SSD_PAIR_RST 8'h00
`endif

/* File: design/ssd_pkg.sv */
package ssd_pkg;
	// Message shown on the display
	typedef enum logic [3:0] {
		MSG_TYPE = 4'h0,
		MSG_VERSION = 4'h1,
		MSG_SERIAL = 4'h2,
		MSG_NAME = 4'h3,
		MSG_ADDR = 4'h4,
		MSG_WIRELESS = 4'h5,
		MSG_SETUP = 4'h6,
		MSG_CFG_DATE = 4'h7,
		MSG_CFG_SIG = 4'h8,
		MSG_ALIGN = 4'h9,
		MSG_NORMAL = 4'ha,
		MSG_WAIT = 4'hb,
		MSG_XFER = 4'hc,
		MSG_IDENT = 4'hd,
		MSG_DIAG = 4'he
	} ssd_msg_t;
	// Diagnostic class
	typedef enum logic [2:0] {
		CLS_F = 3'h0,
		CLS_E = 3'h1,
		CLS_U = 3'h2,
		CLS_I = 3'h3,
		CLS_P = 3'h4
	} ssd_cls_t;
	// Sequencer phase
	typedef enum logic [0:0] {
		ST_BOOT = 1'b0,
		ST_RUN = 1'b1
	} ssd_st_t;
endpackage

/* File: design/ssd_top.sv */
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ssd_params.svh"
// How it works
// RULE1: A 24-position refresh scan drives the display, and in normal running the active field pair is shown.
// RULE2: Booting without a stored setup cycles type, version, serial, name, address, wireless and setup-needed, then shows the alignment readout.
// RULE3: Booting with a stored setup cycles type to wireless, then date, signature and alignment, then shows the field pair.
// RULE4: The alignment readout carries the letter H before the horizontal angle and V before the vertical one.
// RULE5: While software flags waiting for setup approval, the wait-for-setup message stays up.
// RULE6: While software flags a setup transfer, the transfer-in-progress message stays up.
// RULE7: An identify request shows the identify message with the device name index for one dwell time.
// RULE8: A diagnostic message carries its source kind (signal output or diagnosis id) and source number.
// RULE9: Diagnostic classes map to the letters F, E, U, I and P.
// RULE10: A diagnostic shows its class letter first and its number code after it.
// RULE11: A non-locking error clears itself ten seconds after it was raised and never drives any restart.
// RULE12: A blocking error holds the error display until the next reset.
// RULE13: Once the protective field has been free about five seconds the diagnostic display gives way; the code also waits until err_ff has cleared.
// RULE14: Software can switch the display off and mirror its positions for upside-down mounting.
module ssd_top #(
	parameter int unsigned AUTOCLR_CYC = `SSD_AUTOCLR_CYC,
	parameter int unsigned FREE_CYC = `SSD_FREE_CYC,
	parameter int unsigned DWELL_CYC = `SSD_DWELL_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic prot_field_occupied,
	output ssd_pkg::ssd_msg_t msg_code,
	output logic [7:0] lead_char,
	output logic [7:0] second_char,
	output logic [11:0] diag_number,
	output logic diag_src_kind,
	output logic [7:0] diag_src_id,
	output logic [7:0] tilt_h,
	output logic [7:0] tilt_v,
	output logic [7:0] field_pair,
	output logic [7:0] name_index,
	output logic display_on,
	output logic rotate_180,
	output logic [4:0] scan_pos,
	output logic [4:0] phys_pos,
	output logic err_active,
	output logic err_blocked,
	output logic automatic_error_clear
);
	import ssd_pkg::*;

	localparam logic [4:0] LAST_COL = 5'(`SSD_COLS - 1);
	localparam logic [`SSD_CNT_W-1:0] AUTOCLR_END = `SSD_CNT_W'(AUTOCLR_CYC - 1);
	localparam logic [`SSD_CNT_W-1:0] FREE_END = `SSD_CNT_W'(FREE_CYC - 1);
	localparam logic [`SSD_CNT_W-1:0] DWELL_END = `SSD_CNT_W'(DWELL_CYC - 1);

	// ==========================================================
	// Bus slave
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [5:0] ctrl_ff;
	logic [15:0] tilt_ff;
	logic [7:0] pair_ff;
	logic [7:0] name_ff;
	ssd_cls_t cls_ff;
	logic [11:0] code_ff;
	logic srck_ff;
	logic [7:0] srcid_ff;
	logic err_ff;
	logic blocked_ff;
	logic diag_show_ff;
	logic ident_ff;
	ssd_st_t st_ff;
	ssd_msg_t step_ff;
	ssd_msg_t msg_ff;
	logic acc;
	logic diag_wr;
	logic ident_wr;

	assign acc = hsel && hready && htrans[1];
	assign diag_wr = wr_pend_ff && (wr_addr_ff == `SSD_OFF_DIAG);
	assign ident_wr = wr_pend_ff && (wr_addr_ff == `SSD_OFF_IDENT);

	// Capture write address phase; zero wait states so hready stays high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= acc && hwrite;
			wr_addr_ff <= haddr[7:0];
		end
	end

	// Read data is fetched at the address phase, so it lags a write just before
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (acc && !hwrite) begin
			if (haddr[7:0] == `SSD_OFF_CTRL) begin
				hrdata_ff <= {26'h0, ctrl_ff};
			end else if (haddr[7:0] == `SSD_OFF_DIAG) begin
				hrdata_ff <= {srcid_ff, 6'h00, srck_ff, blocked_ff, code_ff, 1'b0, cls_ff};
			end else if (haddr[7:0] == `SSD_OFF_TILT) begin
				hrdata_ff <= {16'h0000, tilt_ff};
			end else if (haddr[7:0] == `SSD_OFF_PAIR) begin
				hrdata_ff <= {24'h000000, pair_ff};
			end else if (haddr[7:0] == `SSD_OFF_IDENT) begin
				hrdata_ff <= {24'h000000, name_ff};
			end else if (haddr[7:0] == `SSD_OFF_STAT) begin
				hrdata_ff <= {24'h000000, ident_ff, st_ff, diag_show_ff, blocked_ff,
					err_ff, 3'h0} | {24'h000000, 4'h0, msg_ff};
			end else begin
				hrdata_ff <= 32'h00000000;
			end
		end
	end

	// Plain settings registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `SSD_CTRL_RST;
			tilt_ff <= `SSD_TILT_RST;
			pair_ff <= `SSD_PAIR_RST;
			name_ff <= 8'h00;
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == `SSD_OFF_CTRL) begin
				ctrl_ff <= hwdata[5:0];
			end else if (wr_addr_ff == `SSD_OFF_TILT) begin
				tilt_ff <= hwdata[15:0];
			end else if (wr_addr_ff == `SSD_OFF_PAIR) begin
				pair_ff <= hwdata[7:0];
			end else if (wr_addr_ff == `SSD_OFF_IDENT) begin
				name_ff <= hwdata[7:0];
			end
		end
	end

	// ==========================================================
	// Diagnostics
	logic [`SSD_CNT_W-1:0] err_cnt_ff;
	logic [`SSD_CNT_W-1:0] free_cnt_ff;
	logic [`SSD_CNT_W-1:0] ident_cnt_ff;
	logic auto_clr;
	logic free_done;
	logic auto_clear_ff;

	assign auto_clr = err_ff && !blocked_ff && (err_cnt_ff == AUTOCLR_END);
	assign free_done = (free_cnt_ff == FREE_END);

	// Latch the diagnostic; a blocking one freezes everything after it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cls_ff <= CLS_F;
			code_ff <= 12'h000;
			srck_ff <= 1'b0;
			srcid_ff <= 8'h00;
		end else if (diag_wr && !blocked_ff) begin
			cls_ff <= (hwdata[2:0] > 3'h4) ? CLS_F : ssd_cls_t'(hwdata[2:0]); // RULE9
			code_ff <= hwdata[15:4];
			srck_ff <= hwdata[`SSD_DIAG_SRCK]; // RULE8
			srcid_ff <= hwdata[31:24]; // RULE8
		end
	end

	// New error beats the auto clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_ff <= 1'b0;
			blocked_ff <= 1'b0;
			err_cnt_ff <= '0;
			auto_clear_ff <= 1'b0;
		end else begin
			auto_clear_ff <= auto_clr && !diag_wr;
			if (diag_wr && !blocked_ff) begin
				err_ff <= 1'b1;
				blocked_ff <= hwdata[`SSD_DIAG_BLOCK]; // RULE12
				err_cnt_ff <= '0;
			end else if (auto_clr) begin
				err_ff <= 1'b0; // RULE11
			end else if (err_ff && !blocked_ff) begin
				err_cnt_ff <= err_cnt_ff + 1'b1; // RULE11
			end
		end
	end

	// Free-field timer saturates; any occupation restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			free_cnt_ff <= '0;
		end else if (prot_field_occupied) begin
			free_cnt_ff <= '0;
		end else if (!free_done) begin
			free_cnt_ff <= free_cnt_ff + 1'b1; // RULE13
		end
	end

	// Diagnostic display holds until cleared and the field stays free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			diag_show_ff <= 1'b0;
		end else if (diag_wr && !blocked_ff) begin
			diag_show_ff <= 1'b1;
		end else if (free_done && !err_ff && !blocked_ff) begin
			diag_show_ff <= 1'b0; // RULE13
		end
	end

	// Identify request shown for one dwell time; a repeat request restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ident_ff <= 1'b0;
			ident_cnt_ff <= '0;
		end else if (ident_wr) begin
			ident_ff <= 1'b1; // RULE7
			ident_cnt_ff <= '0;
		end else if (ident_ff) begin
			ident_ff <= (ident_cnt_ff != DWELL_END);
			ident_cnt_ff <= ident_cnt_ff + 1'b1;
		end
	end

	// ==========================================================
	// Boot sequencer
	logic [`SSD_CNT_W-1:0] dwell_cnt_ff;
	ssd_msg_t nxt_step;

	// Step order depends on whether a setup is stored
	always_comb begin
		case (step_ff)
			MSG_TYPE: nxt_step = MSG_VERSION;
			MSG_VERSION: nxt_step = MSG_SERIAL;
			MSG_SERIAL: nxt_step = MSG_NAME;
			MSG_NAME: nxt_step = MSG_ADDR;
			MSG_ADDR: nxt_step = MSG_WIRELESS;
			MSG_WIRELESS: nxt_step = ctrl_ff[`SSD_CTRL_CFG] ? MSG_CFG_DATE : MSG_SETUP; // RULE2 RULE3
			MSG_CFG_DATE: nxt_step = MSG_CFG_SIG; // RULE3
			MSG_CFG_SIG: nxt_step = MSG_ALIGN; // RULE3
			default: nxt_step = MSG_TYPE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= ST_BOOT;
			step_ff <= MSG_TYPE;
			dwell_cnt_ff <= '0;
		end else begin
			case (st_ff)
				ST_BOOT: begin
					if (ctrl_ff[`SSD_CTRL_BOOTEND]) begin
						st_ff <= ST_RUN;
					end else if (dwell_cnt_ff == DWELL_END) begin
						dwell_cnt_ff <= '0;
						step_ff <= nxt_step;
					end else begin
						dwell_cnt_ff <= dwell_cnt_ff + 1'b1;
					end
				end
				default: st_ff <= ST_RUN;
			endcase
		end
	end

	// ==========================================================
	// Message selection, highest priority first
	ssd_msg_t nxt_msg;
	logic [7:0] nxt_lead;
	logic [7:0] nxt_second;

	always_comb begin
		if (st_ff == ST_BOOT) begin
			nxt_msg = step_ff;
		end else if (blocked_ff || diag_show_ff) begin
			nxt_msg = MSG_DIAG; // RULE12
		end else if (ctrl_ff[`SSD_CTRL_XFER]) begin
			nxt_msg = MSG_XFER; // RULE6
		end else if (ctrl_ff[`SSD_CTRL_WAIT]) begin
			nxt_msg = MSG_WAIT; // RULE5
		end else if (ident_ff) begin
			nxt_msg = MSG_IDENT; // RULE7
		end else if (ctrl_ff[`SSD_CTRL_CFG]) begin
			nxt_msg = MSG_NORMAL; // RULE1 RULE3
		end else begin
			nxt_msg = MSG_ALIGN; // RULE2
		end
	end

	// Leading characters: class letter for a diagnostic, H and V for alignment
	always_comb begin
		nxt_lead = `SSD_CH_SP;
		nxt_second = `SSD_CH_SP;
		if (nxt_msg == MSG_DIAG) begin
			case (cls_ff)
				CLS_F: nxt_lead = `SSD_CH_F; // RULE9 RULE10
				CLS_E: nxt_lead = `SSD_CH_E;
				CLS_U: nxt_lead = `SSD_CH_U;
				CLS_I: nxt_lead = `SSD_CH_I;
				default: nxt_lead = `SSD_CH_P;
			endcase
		end else if (nxt_msg == MSG_ALIGN) begin
			nxt_lead = `SSD_CH_H; // RULE4
			nxt_second = `SSD_CH_V; // RULE4
		end
	end

	// ==========================================================
	// Output registers and refresh scan
	logic [7:0] lead_ff;
	logic [7:0] second_ff;
	logic [4:0] scan_ff;
	logic [4:0] phys_ff;
	logic [4:0] nxt_scan;
	logic disp_on_ff;
	logic rot_ff;

	assign nxt_scan = (scan_ff == LAST_COL) ? 5'h00 : scan_ff + 5'h01; // RULE1

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msg_ff <= MSG_TYPE;
			lead_ff <= `SSD_CH_SP;
			second_ff <= `SSD_CH_SP;
		end else begin
			msg_ff <= nxt_msg;
			lead_ff <= nxt_lead;
			second_ff <= nxt_second;
		end
	end

	// Mirroring reverses position order; glyph flipping is the display's job
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_ff <= 5'h00;
			phys_ff <= 5'h00;
			disp_on_ff <= 1'b0;
			rot_ff <= 1'b0;
		end else begin
			scan_ff <= nxt_scan;
			phys_ff <= ctrl_ff[`SSD_CTRL_ROT] ? LAST_COL - nxt_scan : nxt_scan; // RULE14
			disp_on_ff <= !ctrl_ff[`SSD_CTRL_OFF]; // RULE14
			rot_ff <= ctrl_ff[`SSD_CTRL_ROT];
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign msg_code = msg_ff;
	assign lead_char = lead_ff;
	assign second_char = second_ff;
	assign diag_number = code_ff;
	assign diag_src_kind = srck_ff;
	assign diag_src_id = srcid_ff;
	assign tilt_h = tilt_ff[7:0];
	assign tilt_v = tilt_ff[15:8];
	assign field_pair = pair_ff;
	assign name_index = name_ff;
	assign display_on = disp_on_ff;
	assign rotate_180 = rot_ff;
	assign scan_pos = scan_ff;
	assign phys_pos = phys_ff;
	assign err_active = err_ff;
	assign err_blocked = blocked_ff;
	assign automatic_error_clear = auto_clear_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_BLOCK_STICKY: assert property (blocked_ff |=> blocked_ff && err_ff) // RULE12
		else $error("blocking error released");
	AST_BLOCK_SHOWN: assert property (blocked_ff && st_ff == ST_RUN |=> msg_ff == MSG_DIAG) // RULE12
		else $error("blocking error not displayed");
	AST_AUTOCLR: assert property (auto_clr && !diag_wr |=> !err_ff ##0 auto_clear_ff) // RULE11
		else $error("auto clear missed");
	AST_AUTOCLR_TIME: assert property ($fell(err_ff) |-> $past(err_cnt_ff) == AUTOCLR_END) // RULE11
		else $error("auto clear at wrong time");
	AST_DIAG_LEAD: assert property (msg_ff == MSG_DIAG && $past(cls_ff) == CLS_E
		|-> lead_ff == `SSD_CH_E) // RULE10
		else $error("class letter not first");
	AST_XFER: assert property (st_ff == ST_RUN && !blocked_ff && !diag_show_ff
		&& ctrl_ff[`SSD_CTRL_XFER] |=> msg_ff == MSG_XFER) // RULE6
		else $error("transfer message missing");
	AST_WAIT: assert property (st_ff == ST_RUN && !blocked_ff && !diag_show_ff
		&& !ctrl_ff[`SSD_CTRL_XFER] && ctrl_ff[`SSD_CTRL_WAIT] |=> msg_ff == MSG_WAIT) // RULE5
		else $error("wait message missing");
	AST_ALIGN_HV: assert property (msg_ff == MSG_ALIGN |-> lead_ff == `SSD_CH_H
		&& second_ff == `SSD_CH_V) // RULE4
		else $error("alignment letters wrong");
	AST_SCAN_WRAP: assert property (scan_ff == LAST_COL |=> scan_ff == 5'h00) // RULE1
		else $error("scan did not wrap at last column");
	AST_ROT: assert property (phys_ff == (rot_ff ? LAST_COL - scan_ff : scan_ff)) // RULE14
		else $error("mirrored position wrong");
	AST_SETUP_STEP: assert property (st_ff == ST_BOOT && step_ff == MSG_WIRELESS
		&& !ctrl_ff[`SSD_CTRL_CFG] && dwell_cnt_ff == DWELL_END
		&& !ctrl_ff[`SSD_CTRL_BOOTEND] |=> step_ff == MSG_SETUP) // RULE2
		else $error("setup-needed step skipped");
	AST_FREE_RETURN: assert property (diag_show_ff && free_done && !err_ff && !blocked_ff
		&& !diag_wr |=> !diag_show_ff) // RULE13
		else $error("diagnostic display did not give way");

	COV_AUTOCLR: cover property (auto_clear_ff);
	COV_BLOCK: cover property ($rose(blocked_ff));
	COV_IDENT: cover property (msg_ff == MSG_IDENT);
	COV_NORMAL: cover property ($past(msg_ff) == MSG_DIAG && msg_ff == MSG_NORMAL);
endmodule

/* File: verif/ssd_disp_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Character display fed by the sequencer
module ssd_disp_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic display_on,
	input wire logic [4:0] phys_pos,
	output logic all_lit,
	output logic pos_bad
);
	logic [23:0] lit_ff;
	logic pos_bad_ff;
	// Mark each cell as it is refreshed; a dark display refreshes nothing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lit_ff <= 24'h000000;
			pos_bad_ff <= 1'b0;
		end else if (display_on) begin
			if (phys_pos > 5'h17) begin
				pos_bad_ff <= 1'b1;
			end else begin
				lit_ff[phys_pos] <= 1'b1;
			end
		end
	end
	// Only 24 cells exist, so any wider scan is a fault
	assign all_lit = &lit_ff;
	assign pos_bad = pos_bad_ff;
endmodule

/* File: verif/tb_status_text_display_sequencer.sv */
`timescale 1ns/1ps
module tb_status_text_display_sequencer;
	import ssd_pkg::*;
	// Short counts keep the run brief; expectations follow them
	localparam int unsigned AC = 40;
	localparam int unsigned FC = 20;
	localparam int unsigned DC = 8;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic prot_field_occupied = 1'b0;
	logic hready, hreadyout, hresp, diag_src_kind, display_on, rotate_180;
	logic [31:0] hrdata;
	ssd_msg_t msg_code;
	logic [7:0] lead_char, second_char, diag_src_id, tilt_h, tilt_v, field_pair, name_index;
	logic [11:0] diag_number;
	logic [4:0] scan_pos, phys_pos;
	logic err_active, err_blocked, automatic_error_clear, all_lit, pos_bad;
	logic [31:0] rd;
	int err_total = 0;
	int comparisons = 0;
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	ssd_top #(.AUTOCLR_CYC(AC), .FREE_CYC(FC), .DWELL_CYC(DC)) u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hrdata, .hresp, .prot_field_occupied, .msg_code, .lead_char,
		.second_char, .diag_number, .diag_src_kind, .diag_src_id, .tilt_h, .tilt_v,
		.field_pair, .name_index, .display_on, .rotate_180, .scan_pos, .phys_pos,
		.err_active, .err_blocked, .automatic_error_clear
	);
	ssd_disp_model u_disp (.hclk, .hresetn, .display_on, .phys_pos, .all_lit, .pos_bad);
	// ==========================================================
	// Clock and watchdog
	initial begin
		forever #50 hclk = ~hclk;
	end
	initial begin
		#500000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	// Address phase held until ready, then data phase until ready
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, rd);
	endtask
	task automatic do_reset();
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	// Wait for the next boot step, bounded, and check its length
	task automatic next_msg(input ssd_msg_t exp, input logic timed);
		ssd_msg_t cur;
		int n;
		cur = msg_code;
		n = 0;
		while (msg_code === cur && n < 4 * DC) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(msg_code, exp, "boot step message");
		if (timed) chk(n, DC, "boot step dwell");
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		@(posedge hclk);
		#1;
		chk({display_on, msg_code, lead_char}, {1'b0, MSG_TYPE, 8'h20}, "reset state");
		chk({hreadyout, hresp}, 2'b10, "bus idle answer");
		@(posedge hclk);
		hresetn <= 1'b1;
		cyc(2);
		chk(display_on, 1'b1, "display lit");
		$display("t_reset done");
	endtask
	task automatic t_boot(input logic cfg);
		ssd_msg_t s [8];
		if (cfg) begin
			wr(32'h0, 32'h4);
			s = '{MSG_VERSION, MSG_SERIAL, MSG_NAME, MSG_ADDR, MSG_WIRELESS, MSG_CFG_DATE,
				MSG_CFG_SIG, MSG_ALIGN};
		end else begin
			s = '{MSG_VERSION, MSG_SERIAL, MSG_NAME, MSG_ADDR, MSG_WIRELESS, MSG_SETUP,
				MSG_TYPE, MSG_VERSION};
		end
		chk(msg_code, MSG_TYPE, "boot opens with type");
		for (int i = 0; i < 8; i++) begin
			next_msg(s[i], i > 0);
		end
		$display("t_boot done");
	endtask
	task automatic t_align();
		wr(32'h8, 32'h09fd);
		wr(32'h0, 32'h8);
		cyc(2);
		chk(msg_code, MSG_ALIGN, "alignment after boot");
		chk({lead_char, tilt_h, second_char, tilt_v}, 32'h48fd5609, "tilt readout");
		cyc(3 * DC);
		chk(msg_code, MSG_ALIGN, "alignment stays");
		$display("t_align done");
	endtask
	task automatic t_wait_xfer();
		wr(32'h0, 32'h18);
		cyc(20);
		chk(msg_code, MSG_WAIT, "wait message held");
		wr(32'h0, 32'h38);
		cyc(20);
		chk(msg_code, MSG_XFER, "transfer message held");
		wr(32'h0, 32'h8);
		cyc(2);
		chk(msg_code, MSG_ALIGN, "back to alignment");
		$display("t_wait_xfer done");
	endtask
	task automatic t_ident();
		wr(32'h10, 32'h5a);
		cyc(2);
		chk({msg_code, name_index}, {MSG_IDENT, 8'h5a}, "identify with name");
		cyc(DC + 2);
		chk(msg_code, MSG_ALIGN, "identify ends");
		$display("t_ident done");
	endtask
	// Every class code, plus one out of range that falls back to F
	task automatic t_diag();
		logic [7:0] ltr [6];
		ltr = '{8'h46, 8'h45, 8'h55, 8'h49, 8'h50, 8'h46};
		@(posedge hclk);
		prot_field_occupied <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			wr(32'h4, {8'h70 + c[7:0], 6'h0, c[0], 1'b0, 12'h120 + c[11:0], 1'b0, c[2:0]});
			cyc(2);
			chk(msg_code, MSG_DIAG, "diag shown");
			chk({lead_char, diag_number}, {ltr[c], 12'h120 + c[11:0]}, "letter then code");
			chk({diag_src_kind, diag_src_id}, {c[0], 8'h70 + c[7:0]}, "diag source");
		end
		$display("t_diag done");
	endtask
	task automatic t_clear();
		int n;
		wr(32'h4, 32'h00000451);
		n = 0;
		while (automatic_error_clear !== 1'b1 && n < AC + 10) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(n, AC, "auto clear delay");
		chk(err_active, 1'b0, "error cleared");
		chk(msg_code, MSG_DIAG, "diag held while occupied");
		@(posedge hclk);
		prot_field_occupied <= 1'b0;
		cyc(FC - 4);
		chk(msg_code, MSG_DIAG, "diag before free time");
		cyc(8);
		chk(msg_code, MSG_ALIGN, "normal after free time");
		$display("t_clear done");
	endtask
	task automatic t_block();
		int seen;
		wr(32'h4, 32'h00010330);
		seen = 0;
		repeat (AC + FC + 10) begin
			@(posedge hclk);
			#1;
			if (automatic_error_clear === 1'b1) seen++;
		end
		chk(seen, 0, "no auto clear when blocked");
		chk({err_blocked, msg_code}, {1'b1, MSG_DIAG}, "blocked diag held");
		wr(32'h4, 32'h00000451);
		cyc(2);
		chk(lead_char, 8'h46, "new diag ignored");
		ahb(1'b0, 32'h4, 32'h0, rd);
		chk(rd[16], 1'b1, "blocked read back");
		do_reset();
		cyc(1);
		chk(err_blocked, 1'b0, "restart clears block");
		$display("t_block done");
	endtask
	task automatic t_rot();
		wr(32'hc, 32'h21);
		wr(32'h0, 32'he);
		cyc(2);
		chk({msg_code, field_pair}, {MSG_NORMAL, 8'h21}, "field pair display");
		chk({rotate_180, all_lit, pos_bad}, 3'b110, "rotated full scan");
		chk(phys_pos, 5'd23 - scan_pos, "mirrored position");
		ahb(1'b0, 32'h0, 32'h0, rd);
		chk(rd, 32'he, "control read back");
		wr(32'h0, 32'hf);
		cyc(2);
		chk(display_on, 1'b0, "display off");
		ahb(1'b0, 32'h40, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		wr(32'h14, 32'hff);
		ahb(1'b0, 32'h14, 32'h0, rd);
		chk(rd, 32'h4a, "status read only");
		$display("t_rot done");
	endtask
	// ==========================================================
	// Main sequence and verdict
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		t_reset();
		t_boot(1'b0);
		t_align();
		t_wait_xfer();
		t_ident();
		t_diag();
		t_clear();
		t_block();
		t_boot(1'b1);
		t_rot();
		complete_run();
	end
endmodule
